// file: design/eeprom_addr_pkg.sv
// Constants and carrier types for the two-wire slave addressing front end
package eeprom_addr_pkg;
	localparam logic [3:0] type_array    = 4'ha;
	localparam logic [3:0] type_security = 4'hb;
	localparam logic [3:0] bit_ack_slot  = 4'h8;
	localparam logic [3:0] bit_reset_val = 4'h0;
	localparam logic [7:0] page_bytes    = 8'h08;
	localparam logic [7:0] sec_base      = 8'h80;
	localparam logic [7:0] sec_user_base = 8'h90;
	localparam int         sync_stages   = 3;

	typedef enum logic [2:0] {
		tgt_none,
		tgt_array,
		tgt_security,
		tgt_lock,
		tgt_protect
	} target_t;

	typedef struct packed {
		logic [7:0] addr;
		target_t    target;
		logic       read;
		logic       sec_read_only;
	} decode_t;

	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       ready;
	} byte_port_t;
endpackage

// file: design/byte_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module byte_skid #(
	parameter int width = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [width-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [width-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	typedef struct packed {
		logic [1:0][width-1:0] mem;
		logic                  rd;
		logic                  wr;
		logic [1:0]            count;
	} skid_state_t;

	skid_state_t state;
	skid_state_t next_state;
	logic        push;
	logic        pop;

	always_comb
	begin
		next_state = state;
		push = in_valid && (state.count != 2'h2);
		pop = out_ready && (state.count != 2'h0);
		if (push)
		begin
			next_state.mem[state.wr] = in_data;
			next_state.wr = ~state.wr;
		end
		if (pop)
			next_state.rd = ~state.rd;
		next_state.count = state.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			state <= '0;
		else
			state <= next_state;
	end

	assign in_ready = state.count != 2'h2;
	assign out_valid = state.count != 2'h0;
	assign out_data = state.mem[state.rd];

	count_bound_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state.count <= 2'h2) else $error("skid count above two");
endmodule // byte_skid

// file: design/eeprom_i2c_slave_addressing.sv
// Two-wire slave front end: framing, acknowledge, standby and address decode
`timescale 1ns/100ps
module eeprom_i2c_slave_addressing #(
	parameter logic [2:0] hw_addr   = 3'h0,
	parameter bit         is_2kbit  = 1'b1
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_n,
	input  wire logic                     write_busy,
	output logic                          write_request,
	output logic                          standby,
	output logic                          tx_load,
	input  wire logic [7:0]               tx_data,
	output eeprom_addr_pkg::decode_t      decode,
	output logic                          decode_valid,
	output logic [7:0]                    rx_data,
	output logic                          rx_valid,
	input  wire logic                     rx_ready,
	output logic                          rx_overflow
);
	typedef enum logic [2:0] {
		st_idle,
		st_dev_addr,
		st_word_addr,
		st_data_in,
		st_data_out,
		st_ignore
	} phase_t;

	typedef struct packed {
		logic [2:0]                scl_sync;
		logic [2:0]                sda_sync;
		phase_t                    phase;
		logic [3:0]                bit_cnt;
		logic [7:0]                shift;
		logic [7:0]                tx_shift;
		logic                      drive_low;
		logic                      ack_pending;
		logic                      master_nack;
		logic                      wrote_data;
		logic [3:0]                dev_type;
		logic                      rd;
		eeprom_addr_pkg::decode_t  dec;
		logic                      dec_valid;
		logic                      write_req;
		logic                      stby;
		logic                      tx_ld;
		logic                      ovf;
		logic [7:0]                push_data;
		logic                      push;
		logic                      seen_rise;
		logic                      busy_prev;
	} slave_state_t;

	slave_state_t state;
	slave_state_t next_state;
	logic         skid_ready;
	logic         skid_valid;
	logic [7:0]   skid_data;
	logic         scl_q;
	logic         sda_q;
	logic         scl_prev;
	logic         sda_prev;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_seen;
	logic         stop_seen;
	logic         dev_match;
	logic [7:0]   full_byte;

	function automatic eeprom_addr_pkg::decode_t decode_word(
		input logic [3:0] dtype,
		input logic [7:0] word,
		input logic       rd,
		input bit         big
	);
		eeprom_addr_pkg::decode_t d;
		d = '0;
		d.read = rd;
		if (dtype == eeprom_addr_pkg::type_array)
		begin
			d.target = eeprom_addr_pkg::tgt_array;
			d.addr = big ? word : {1'b0, word[6:0]};
		end
		else if (word[7:6] == 2'b11)
			d.target = eeprom_addr_pkg::tgt_protect;
		else if (word[7:4] == 4'h6)
			d.target = eeprom_addr_pkg::tgt_lock;
		else if (word[7:6] == 2'b10)
		begin
			d.target = eeprom_addr_pkg::tgt_security;
			d.addr = eeprom_addr_pkg::sec_base | {3'h0, word[4:0]};
			d.sec_read_only = (d.addr < eeprom_addr_pkg::sec_user_base);
		end
		else
			d.target = eeprom_addr_pkg::tgt_none;
		return d;
	endfunction

	// A pin change is found where the second and third stages differ
	always_comb
	begin
		scl_q = state.scl_sync[1];
		sda_q = state.sda_sync[1];
		scl_prev = state.scl_sync[2];
		sda_prev = state.sda_sync[2];
		scl_rise = scl_q && !scl_prev;
		scl_fall = !scl_q && scl_prev;
		start_seen = scl_q && scl_prev && sda_prev && !sda_q;
		stop_seen = scl_q && scl_prev && !sda_prev && sda_q;
		full_byte = {state.shift[6:0], sda_q};
		dev_match = ((full_byte[7:4] == eeprom_addr_pkg::type_array)
			|| (full_byte[7:4] == eeprom_addr_pkg::type_security))
			&& (full_byte[3:1] == hw_addr) && !write_busy;
	end

	always_comb
	begin
		next_state = state;
		next_state.scl_sync = {state.scl_sync[1:0], scl_in};
		next_state.sda_sync = {state.sda_sync[1:0], sda_in};
		next_state.dec_valid = 1'b0;
		next_state.write_req = 1'b0;
		next_state.tx_ld = 1'b0;
		next_state.push = 1'b0;
		next_state.busy_prev = write_busy;
		// Write done returns an idle part to standby
		if (state.busy_prev && !write_busy
			&& (state.phase == st_idle || state.phase == st_ignore))
			next_state.stby = 1'b1;
		if (state.push && !skid_ready)
			next_state.ovf = 1'b1;
		if (start_seen && !write_busy)
		begin
			// Repeated Start doubles as the tail of the bus recovery
			next_state.phase = st_dev_addr;
			next_state.bit_cnt = eeprom_addr_pkg::bit_reset_val;
			next_state.seen_rise = 1'b0;
			next_state.drive_low = 1'b0;
			next_state.ack_pending = 1'b0;
			next_state.wrote_data = 1'b0;
			next_state.stby = 1'b0;
		end
		else if (stop_seen)
		begin
			next_state.phase = st_idle;
			next_state.drive_low = 1'b0;
			// A Stop that launches a write leaves the part busy, not in standby
			next_state.stby = !state.wrote_data;
			if (state.wrote_data)
				next_state.write_req = 1'b1;
			next_state.wrote_data = 1'b0;
		end
		else if (state.phase != st_idle && state.phase != st_ignore)
		begin
			if (scl_rise)
			begin
				next_state.seen_rise = 1'b1;
				if (state.bit_cnt == eeprom_addr_pkg::bit_ack_slot)
					next_state.master_nack = sda_q;
				else
					next_state.shift = full_byte;
				if (state.bit_cnt == 4'h7)
				begin
					case (state.phase)
						st_dev_addr:
						begin
							next_state.ack_pending = dev_match;
							next_state.dev_type = full_byte[7:4];
							next_state.rd = full_byte[0];
						end
						st_word_addr:
						begin
							next_state.ack_pending = 1'b1;
							next_state.dec = decode_word(state.dev_type, full_byte,
								1'b0, is_2kbit);
							next_state.dec_valid = 1'b1;
						end
						st_data_in:
						begin
							next_state.ack_pending = 1'b1;
							next_state.push_data = full_byte;
							next_state.push = 1'b1;
							next_state.wrote_data = 1'b1;
						end
						default:
							next_state.ack_pending = 1'b0;
					endcase
				end
			end
			// The fall that closes a Start carries no bit and is not counted
			else if (scl_fall && state.seen_rise)
			begin
				next_state.seen_rise = 1'b0;
				if (state.bit_cnt == eeprom_addr_pkg::bit_ack_slot)
				begin
					next_state.bit_cnt = eeprom_addr_pkg::bit_reset_val;
					next_state.drive_low = 1'b0;
					case (state.phase)
						st_dev_addr:
						begin
							if (!state.ack_pending)
							begin
								next_state.phase = st_ignore;
								next_state.stby = 1'b1;
							end
							else if (state.rd)
							begin
								next_state.phase = st_data_out;
								next_state.dec.read = 1'b1;
								next_state.dec_valid = 1'b1;
								next_state.tx_shift = tx_data;
								next_state.tx_ld = 1'b1;
								next_state.drive_low = !tx_data[7];
							end
							else
								next_state.phase = st_word_addr;
						end
						st_word_addr:
							next_state.phase = st_data_in;
						st_data_out:
						begin
							if (state.master_nack)
							begin
								next_state.phase = st_ignore;
								next_state.stby = 1'b1;
							end
							else
							begin
								next_state.tx_shift = tx_data;
								next_state.tx_ld = 1'b1;
								next_state.drive_low = !tx_data[7];
							end
						end
						default:
							next_state.phase = state.phase;
					endcase
				end
				else
				begin
					next_state.bit_cnt = state.bit_cnt + 4'h1;
					if (state.bit_cnt == 4'h7)
						// Own data released here; acknowledge driven if owed
						next_state.drive_low = (state.phase != st_data_out)
							&& state.ack_pending;
					else if (state.phase == st_data_out)
						next_state.drive_low = !state.tx_shift[3'h6 - state.bit_cnt[2:0]];
				end
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state <= '0;
			state.scl_sync <= 3'h7;
			state.sda_sync <= 3'h7;
			state.phase <= st_idle;
			state.stby <= 1'b1;
		end
		else
			state <= next_state;
	end

	byte_skid #(
		.width(8)
	) u_skid (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.in_data  (state.push_data),
		.in_valid (state.push),
		.in_ready (skid_ready),
		.out_data (skid_data),
		.out_valid(skid_valid),
		.out_ready(rx_ready)
	);

	// Data only ever pulled low, enable low means driving
	assign sda_out = 1'b0;
	assign sda_oe_n = !state.drive_low;
	assign write_request = state.write_req;
	assign standby = state.stby;
	assign tx_load = state.tx_ld;
	assign decode = state.dec;
	assign decode_valid = state.dec_valid;
	assign rx_data = skid_data;
	assign rx_valid = skid_valid;
	assign rx_overflow = state.ovf;

	drive_on_fall_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		$changed(sda_oe_n) |-> $past(scl_fall) || $past(stop_seen) || $past(start_seen))
		else $error("data line changed away from clock fall");
	start_restart_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		start_seen && !write_busy |=> state.phase == st_dev_addr && state.bit_cnt == 4'h0)
		else $error("start did not restart address phase");
	stop_standby_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		stop_seen && !start_seen && !state.wrote_data |=> standby && state.phase == st_idle)
		else $error("stop did not give standby");
	ack_slot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!sda_oe_n && state.bit_cnt == 4'h8 |-> state.ack_pending)
		else $error("acknowledge driven without cause");
	nack_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		scl_fall && state.bit_cnt == 4'h8 && state.phase == st_dev_addr
		&& !state.ack_pending && !start_seen && !stop_seen
		|=> sda_oe_n && standby) else $error("mismatch not released");
	idle_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state.phase == st_idle || state.phase == st_ignore |-> sda_oe_n)
		else $error("line driven while idle");
	read_nack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state.phase == st_data_out && state.master_nack && scl_fall
		&& state.bit_cnt == 4'h8 && !start_seen && !stop_seen
		|=> state.phase == st_ignore ##1 sda_oe_n)
		else $error("read no-acknowledge not honoured");
	release_eighth_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		scl_fall && state.bit_cnt == 4'h7 && state.phase == st_data_out
		&& !start_seen && !stop_seen |=> sda_oe_n)
		else $error("transmitter kept line at eighth fall");
	write_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		stop_seen && state.wrote_data |=> write_request && !standby)
		else $error("stop after data did not launch a write");
	busy_done_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state.busy_prev && !write_busy && state.phase == st_idle && !start_seen
		|=> standby) else $error("write completion did not give standby");
	ack_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		scl_fall && state.seen_rise && state.bit_cnt == 4'h7 && state.ack_pending
		&& (state.phase == st_dev_addr || state.phase == st_word_addr
		|| state.phase == st_data_in) |=> !sda_oe_n)
		else $error("owed acknowledge not driven");
	fall_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		scl_fall && !state.seen_rise |=> state.bit_cnt == $past(state.bit_cnt))
		else $error("clock fall counted without a sampled bit");
	bit_range_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		state.bit_cnt <= eeprom_addr_pkg::bit_ack_slot)
		else $error("bit counter beyond acknowledge slot");
	read_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		scl_fall && state.seen_rise && state.bit_cnt == 4'h8 && state.phase == st_dev_addr
		&& state.ack_pending && state.rd |=> tx_load && decode_valid && decode.read)
		else $error("read address did not load first byte");
	start_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		start_seen && !write_busy |=> sda_oe_n)
		else $error("start did not release data line");
endmodule // eeprom_i2c_slave_addressing

// file: bench/host_model.sv
// Two-wire bus master model driving the serial clock and pulling data low
`timescale 1ns/100ps
module host_model (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      pull
);
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Clock stands high between frames
	task automatic start();
		pull = 1'b0;
		q(2);
		scl = 1'b1;
		q(4);
		pull = 1'b1;
		q(4);
		scl = 1'b0;
		q(2);
	endtask
	task automatic stop();
		pull = 1'b1;
		q(2);
		scl = 1'b1;
		q(4);
		pull = 1'b0;
		q(4);
	endtask
	// Sampled late in the high phase: device answers lag behind its synchroniser
	task automatic bit_slot(input logic b, output logic r);
		pull = ~b;
		q(2);
		scl = 1'b1;
		q(4);
		r = sda;
		scl = 1'b0;
		q(2);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_slot(b[i], r);
		bit_slot(1'b1, r);
		ack = ~r;
	endtask
	task automatic recv_byte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_slot(1'b1, d[i]);
		bit_slot(~ack, r);
	endtask
endmodule // host_model

// file: bench/eeprom_i2c_slave_addressing_bench.sv
// Bench for the two-wire slave addressing front end
`timescale 1ns/100ps
module eeprom_i2c_slave_addressing_bench;
	typedef struct packed {
		logic [7:0]               dev;
		logic [7:0]               word;
		logic                     ack;
		eeprom_addr_pkg::target_t tgt;
		logic                     ro;
	} row_t;
	logic                     ref_clk = 1'b0;
	logic                     rstn = 1'b0;
	logic                     scl;
	logic                     pull;
	wire logic                sda;
	logic                     sda_out;
	logic                     sda_oe_n;
	logic                     write_busy = 1'b0;
	logic                     write_request;
	logic                     standby;
	logic                     tx_load;
	eeprom_addr_pkg::decode_t decode;
	eeprom_addr_pkg::decode_t cap;
	logic                     decode_valid;
	logic [7:0]               rx_data;
	logic                     rx_valid;
	logic                     rx_ready = 1'b1;
	logic                     rx_overflow;
	logic [7:0]               cap_n = 8'h00;
	logic [7:0]               wr_n = 8'h00;
	logic [7:0]               tl_n = 8'h00;
	logic [7:0]               d;
	logic                     ack;
	int                       num_errors = 0;
	int                       num_checks = 0;
	row_t                     rows [8];

	// Pull-up wins unless someone pulls low
	assign sda = ~(pull | ~(sda_oe_n | sda_out));
	always #10 ref_clk = ~ref_clk;

	eeprom_i2c_slave_addressing #(
		.hw_addr  (3'h5),
		.is_2kbit (1'b1)
	) i_eeprom_i2c_slave_addressing (
		.ref_clk       (ref_clk),
		.rstn          (rstn),
		.scl_in        (scl),
		.sda_in        (sda),
		.sda_out       (sda_out),
		.sda_oe_n      (sda_oe_n),
		.write_busy    (write_busy),
		.write_request (write_request),
		.standby       (standby),
		.tx_load       (tx_load),
		.tx_data       (8'h96),
		.decode        (decode),
		.decode_valid  (decode_valid),
		.rx_data       (rx_data),
		.rx_valid      (rx_valid),
		.rx_ready      (rx_ready),
		.rx_overflow   (rx_overflow)
	);

	host_model i_host_model (
		.ref_clk (ref_clk),
		.sda     (sda),
		.scl     (scl),
		.pull    (pull)
	);

	always @(posedge ref_clk)
	begin
		if (decode_valid === 1'b1)
		begin
			cap <= decode;
			cap_n <= cap_n + 8'h01;
		end
		if (write_request === 1'b1)
			wr_n <= wr_n + 8'h01;
		if (tx_load === 1'b1)
			tl_n <= tl_n + 8'h01;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic s);
		chk8(n, {7'h00, e}, {7'h00, s});
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic addr(input logic [7:0] b, input logic e);
		i_host_model.start();
		i_host_model.send_byte(b, ack);
		chk1("address ack", e, ack);
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		stop_test();
	end

	initial
	begin
		rows[0] = '{8'haa, 8'h3c, 1'b1, eeprom_addr_pkg::tgt_array, 1'b0};
		rows[1] = '{8'haa, 8'hff, 1'b1, eeprom_addr_pkg::tgt_array, 1'b0};
		rows[2] = '{8'hba, 8'h85, 1'b1, eeprom_addr_pkg::tgt_security, 1'b1};
		rows[3] = '{8'hba, 8'hb3, 1'b1, eeprom_addr_pkg::tgt_security, 1'b0};
		rows[4] = '{8'hba, 8'h6f, 1'b1, eeprom_addr_pkg::tgt_lock, 1'b0};
		rows[5] = '{8'hba, 8'hc7, 1'b1, eeprom_addr_pkg::tgt_protect, 1'b0};
		rows[6] = '{8'ha8, 8'h00, 1'b0, eeprom_addr_pkg::tgt_none, 1'b0};
		rows[7] = '{8'hca, 8'h00, 1'b0, eeprom_addr_pkg::tgt_none, 1'b0};
		w(8);
		rstn = 1'b1;
		chk1("sda_out", 1'b0, sda_out);
		chk1("standby", 1'b1, standby);
		chk1("oe_n", 1'b1, sda_oe_n);
		w(4);
		for (int i = 0; i < 8; i++)
		begin
			addr(rows[i].dev, rows[i].ack);
			if (rows[i].ack)
			begin
				i_host_model.send_byte(rows[i].word, ack);
				w(6);
				chk1("oe_n", 1'b1, sda_oe_n);
				chk8("decodes", 8'(i + 1), cap_n);
				chk8("target", {5'h00, rows[i].tgt}, {5'h00, cap.target});
				chk1("read", 1'b0, cap.read);
				if (i < 2)
					chk8("addr", rows[i].word, cap.addr);
				if (i == 2 || i == 3)
				begin
					chk1("read only", rows[i].ro, cap.sec_read_only);
					chk8("sec addr", {3'h4, rows[i].word[4:0]}, cap.addr);
				end
			end
			else
			begin
				// Standby follows the refused acknowledge slot by a few clocks
				w(2);
				chk1("standby", 1'b1, standby);
			end
			i_host_model.stop();
			w(6);
			chk1("standby", 1'b1, standby);
		end
		chk8("write requests", 8'h00, wr_n);
		addr(8'hab, 1'b1);
		i_host_model.recv_byte(d, 1'b0);
		chk8("read data", 8'h96, d);
		chk1("read", 1'b1, cap.read);
		w(6);
		chk1("standby", 1'b1, standby);
		chk1("oe_n", 1'b1, sda_oe_n);
		chk8("loads", 8'h01, tl_n);
		i_host_model.stop();
		write_busy = 1'b1;
		addr(8'haa, 1'b0);
		i_host_model.stop();
		write_busy = 1'b0;
		addr(8'haa, 1'b1);
		addr(8'ha8, 1'b0);
		addr(8'haa, 1'b1);
		i_host_model.stop();
		addr(8'hff, 1'b0);
		i_host_model.start();
		i_host_model.stop();
		addr(8'haa, 1'b1);
		rx_ready = 1'b0;
		i_host_model.send_byte(8'h10, ack);
		i_host_model.send_byte(8'h5a, ack);
		i_host_model.send_byte(8'hc3, ack);
		chk1("rx_valid", 1'b1, rx_valid);
		i_host_model.send_byte(8'h77, ack);
		chk1("overflow", 1'b1, rx_overflow);
		i_host_model.stop();
		w(6);
		chk8("write requests", 8'h01, wr_n);
		chk1("standby", 1'b0, standby);
		chk8("rx_data", 8'h5a, rx_data);
		rx_ready = 1'b1;
		w(1);
		rx_ready = 1'b0;
		w(1);
		chk8("rx_data", 8'hc3, rx_data);
		rx_ready = 1'b1;
		w(2);
		chk1("rx_valid", 1'b0, rx_valid);
		write_busy = 1'b1;
		w(2);
		write_busy = 1'b0;
		w(2);
		chk1("standby", 1'b1, standby);
		addr(8'haa, 1'b1);
		rstn = 1'b0;
		w(3);
		chk1("standby", 1'b1, standby);
		chk1("oe_n", 1'b1, sda_oe_n);
		chk1("overflow", 1'b0, rx_overflow);
		rstn = 1'b1;
		w(4);
		i_host_model.stop();
		addr(8'haa, 1'b1);
		i_host_model.stop();
		stop_test();
	end
endmodule // eeprom_i2c_slave_addressing_bench
